// *** verilog/dps_pkg.sv ***
// package of offsets, fields, resets and codes for the dac path setup registers
package dps_pkg;

  // ------------------------------------------------------------
  // register byte addresses (printed offsets not all multiples of four)
  // ------------------------------------------------------------
  localparam logic [7:0]  IDX_REC_SEL     = 8'h3D;
  localparam logic [7:0]  IDX_DSP_CFG     = 8'h3E;
  localparam logic [7:0]  IDX_DAC_PWR     = 8'h3F;
  localparam logic [7:0]  IDX_DAC_MUTE    = 8'h40;
  localparam logic [9:0]  ADDR_REC_SEL    = {IDX_REC_SEL, 2'h0};
  localparam logic [9:0]  ADDR_DSP_CFG    = {IDX_DSP_CFG, 2'h0};
  localparam logic [9:0]  ADDR_DAC_PWR    = {IDX_DAC_PWR, 2'h0};
  localparam logic [9:0]  ADDR_DAC_MUTE   = {IDX_DAC_MUTE, 2'h0};

  // ------------------------------------------------------------
  // reset values and writable masks
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_REC_SEL     = 8'h01;
  localparam logic [7:0]  RST_DSP_CFG     = 8'h00;
  localparam logic [7:0]  RST_DAC_PWR     = 8'h14;
  localparam logic [7:0]  RST_DAC_MUTE    = 8'h0C;
  localparam logic [7:0]  MSK_REC_SEL     = 8'h1F;
  localparam logic [7:0]  MSK_DSP_CFG     = 8'h77;
  localparam logic [7:0]  MSK_DAC_PWR     = 8'hFF;
  localparam logic [7:0]  MSK_DAC_MUTE    = 8'hFF;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int          B_REC_AUX_A     = 6;
  localparam int          B_REC_AUX_B     = 5;
  localparam int          B_REC_KEEP      = 4;
  localparam int          B_PLY_AUX_A     = 2;
  localparam int          B_PLY_AUX_B     = 1;
  localparam int          B_PLY_KEEP      = 0;
  localparam int          B_LPWR          = 7;
  localparam int          B_RPWR          = 6;
  localparam int          B_LSRC          = 4;
  localparam int          B_RSRC          = 2;
  localparam int          B_STEP          = 0;
  localparam int          B_RMOD_INV      = 7;
  localparam int          B_AMUTE         = 4;
  localparam int          B_LMUTE         = 3;
  localparam int          B_RMUTE         = 2;
  localparam int          B_GANG          = 0;

  // ------------------------------------------------------------
  // codes
  // ------------------------------------------------------------
  localparam logic [4:0]  REC_SEL_DSP     = 5'h00;
  localparam logic [4:0]  REC_SEL_LAST    = 5'h12;
  localparam logic [1:0]  SRC_NONE        = 2'h0;
  localparam logic [1:0]  SRC_SAME        = 2'h1;
  localparam logic [1:0]  SRC_OTHER       = 2'h2;
  localparam logic [1:0]  SRC_MONO        = 2'h3;
  localparam logic [1:0]  STEP_ONE        = 2'h0;
  localparam logic [1:0]  STEP_TWO        = 2'h1;
  localparam logic [1:0]  STEP_OFF        = 2'h2;
  localparam logic [1:0]  GANG_NONE       = 2'h0;
  localparam logic [1:0]  GANG_R2L        = 2'h1;
  localparam logic [1:0]  GANG_L2R        = 2'h2;
  localparam logic [15:0] AMUTE_BASE      = 16'h0064;

endpackage

// *** verilog/dps_dc_mute.sv ***
// dc-run auto mute detector for one dac channel
`timescale 1ns/1ps
module dps_dc_mute #(
  parameter int DW = 16
) (
  // clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_sys_rst,
  // sample stream
  input  wire logic          i_smp_stb,
  input  wire logic [DW-1:0] i_smp,
  // control
  input  wire logic [2:0]    i_code,
  // result
  output logic               o_muted
);

  logic [DW-1:0] last_q;
  logic [15:0]   run_q;
  logic [15:0]   run_d;
  logic [15:0]   limit;
  logic          same;
  logic          over;

  // ------------------------------------------------------------
  // run length of identical samples
  // ------------------------------------------------------------
  assign limit = dps_pkg::AMUTE_BASE << (i_code - 3'h1);
  assign same  = (i_smp == last_q);
  assign over  = (i_code != 3'h0) && (run_q > limit);
  assign run_d = !same ? 16'h0001 : ((run_q == 16'hFFFF) ? run_q : run_q + 16'h0001);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      last_q  <= '0;
      run_q   <= 16'h0000;
      o_muted <= 1'b0;
    end else begin
      if (i_smp_stb) begin
        last_q <= i_smp;
        run_q  <= run_d;
      end
      o_muted <= over;
    end
  end

endmodule

// *** verilog/dps_regs.sv ***
// apb register bank and control logic for the dac path setup registers
//
// Overview of operation
// - code zero picks record dsp; 1..18 fixed
// - bits 6,5 are record dsp jump conditions
// - bit 4 low clears record counter each frame
// - bits 2,1 are playback dsp jump conditions
// - bit 0 low clears playback counter each frame
// - bit 7 powers left dac, reset off
// - bit 6 powers right dac, reset off
// - left source none, left, right, mono
// - right source none, right, left, mono
// - volume steps per word clock, two, direct
// - right off gives zero or inverted left
// - auto mute after long dc run
// - bit 3 mutes left, reset muted
// - bit 2 mutes right, reset muted
// - volume ganging independent, right-to-left, left-to-right
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module dps_regs #(
  parameter int DW = 16
) (
  // clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_sys_rst,
  // apb slave
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [11:0]   i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic               o_pready,
  output logic [31:0]        o_prdata,
  output logic               o_pslverr,
  // audio frame and interface data
  input  wire logic          i_frame_stb,
  input  wire logic [DW-1:0] i_if_left,
  input  wire logic [DW-1:0] i_if_right,
  input  wire logic          i_lmod,
  // volume targets from the volume registers
  input  wire logic [7:0]    i_lvol_set,
  input  wire logic [7:0]    i_rvol_set,
  // record side dsp controls
  output logic               o_rec_use_dsp,
  output logic [4:0]         o_rec_block,
  output logic               o_rec_sel_bad,
  output logic [1:0]         o_rec_jmp_cond,
  output logic               o_rec_pc_clr,
  // playback side dsp controls
  output logic [1:0]         o_ply_jmp_cond,
  output logic               o_ply_pc_clr,
  // dac channel controls
  output logic               o_lpwr,
  output logic               o_rpwr,
  output logic [DW-1:0]      o_ldac,
  output logic [DW-1:0]      o_rdac,
  output logic               o_rmod,
  output logic               o_lmute,
  output logic               o_rmute,
  output logic [7:0]         o_lvol,
  output logic [7:0]         o_rvol
);

  logic [7:0]    rec_q;
  logic [7:0]    dsp_q;
  logic [7:0]    pwr_q;
  logic [7:0]    mut_q;
  logic          step_ph_q;
  logic [7:0]    lvol_d;
  logic [7:0]    rvol_d;
  logic [7:0]    ltgt;
  logic [7:0]    rtgt;
  logic          step_go;
  logic [DW:0]   mono_sum;
  logic [DW-1:0] mono;
  logic [DW-1:0] lsel;
  logic [DW-1:0] rsel;
  logic          lauto;
  logic          rauto;
  logic          acc;
  logic          wr;
  logic          hit_rec;
  logic          hit_dsp;
  logic          hit_pwr;
  logic          hit_mut;
  logic          hit_any;
  logic [7:0]    rd_byte;
  logic [1:0]    lsrc;
  logic [1:0]    rsrc;
  logic [1:0]    step;
  logic [1:0]    gang;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign acc     = i_psel && i_penable && !o_pready;
  assign wr      = acc && i_pwrite;
  assign hit_rec = (i_paddr[9:0] == dps_pkg::ADDR_REC_SEL) && (i_paddr[11:10] == 2'h0);
  assign hit_dsp = (i_paddr[9:0] == dps_pkg::ADDR_DSP_CFG) && (i_paddr[11:10] == 2'h0);
  assign hit_pwr = (i_paddr[9:0] == dps_pkg::ADDR_DAC_PWR) && (i_paddr[11:10] == 2'h0);
  assign hit_mut = (i_paddr[9:0] == dps_pkg::ADDR_DAC_MUTE) && (i_paddr[11:10] == 2'h0);
  assign hit_any = hit_rec || hit_dsp || hit_pwr || hit_mut;
  assign rd_byte = hit_rec ? rec_q : hit_dsp ? dsp_q : hit_pwr ? pwr_q : hit_mut ? mut_q : 8'h00;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rec_q     <= dps_pkg::RST_REC_SEL;
      dsp_q     <= dps_pkg::RST_DSP_CFG;
      pwr_q     <= dps_pkg::RST_DAC_PWR;
      mut_q     <= dps_pkg::RST_DAC_MUTE;
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= acc;
      o_pslverr <= acc && !hit_any;
      if (acc && !i_pwrite) begin
        o_prdata <= {24'h00_0000, rd_byte};
      end
      if (wr && hit_rec) begin
        rec_q <= i_pwdata[7:0] & dps_pkg::MSK_REC_SEL;
      end
      if (wr && hit_dsp) begin
        dsp_q <= i_pwdata[7:0] & dps_pkg::MSK_DSP_CFG;
      end
      if (wr && hit_pwr) begin
        pwr_q <= i_pwdata[7:0] & dps_pkg::MSK_DAC_PWR;
      end
      if (wr && hit_mut) begin
        mut_q <= i_pwdata[7:0] & dps_pkg::MSK_DAC_MUTE;
      end
    end
  end

  // ------------------------------------------------------------
  // field views
  // ------------------------------------------------------------
  assign lsrc = pwr_q[dps_pkg::B_LSRC +: 2];
  assign rsrc = pwr_q[dps_pkg::B_RSRC +: 2];
  assign step = pwr_q[dps_pkg::B_STEP +: 2];
  assign gang = mut_q[dps_pkg::B_GANG +: 2];

  // ------------------------------------------------------------
  // data path source selection
  // ------------------------------------------------------------
  assign mono_sum = {i_if_left[DW-1], i_if_left} + {i_if_right[DW-1], i_if_right};
  assign mono     = mono_sum[DW:1];
  assign lsel = (lsrc == dps_pkg::SRC_SAME)  ? i_if_left  :
                (lsrc == dps_pkg::SRC_OTHER) ? i_if_right :
                (lsrc == dps_pkg::SRC_MONO)  ? mono : '0;
  assign rsel = (rsrc == dps_pkg::SRC_SAME)  ? i_if_right :
                (rsrc == dps_pkg::SRC_OTHER) ? i_if_left  :
                (rsrc == dps_pkg::SRC_MONO)  ? mono : '0;

  // ------------------------------------------------------------
  // auto mute detectors
  // ------------------------------------------------------------
  dps_dc_mute #(
    .DW        (DW)
  ) u_lmute (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_smp_stb (i_frame_stb),
    .i_smp     (lsel),
    .i_code    (mut_q[dps_pkg::B_AMUTE +: 3]),
    .o_muted   (lauto)
  );

  dps_dc_mute #(
    .DW        (DW)
  ) u_rmute (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_smp_stb (i_frame_stb),
    .i_smp     (rsel),
    .i_code    (mut_q[dps_pkg::B_AMUTE +: 3]),
    .o_muted   (rauto)
  );

  // ------------------------------------------------------------
  // volume ganging and soft stepping
  // ------------------------------------------------------------
  assign ltgt = (gang == dps_pkg::GANG_R2L) ? i_rvol_set : i_lvol_set;
  assign rtgt = (gang == dps_pkg::GANG_L2R) ? i_lvol_set : i_rvol_set;
  assign step_go = i_frame_stb && ((step == dps_pkg::STEP_ONE) ||
                   ((step == dps_pkg::STEP_TWO) && step_ph_q));
  assign lvol_d = (step == dps_pkg::STEP_OFF) ? ltgt :
                  !step_go ? o_lvol :
                  ($signed(o_lvol) < $signed(ltgt)) ? o_lvol + 8'h01 :
                  ($signed(o_lvol) > $signed(ltgt)) ? o_lvol - 8'h01 : o_lvol;
  assign rvol_d = (step == dps_pkg::STEP_OFF) ? rtgt :
                  !step_go ? o_rvol :
                  ($signed(o_rvol) < $signed(rtgt)) ? o_rvol + 8'h01 :
                  ($signed(o_rvol) > $signed(rtgt)) ? o_rvol - 8'h01 : o_rvol;

  // ------------------------------------------------------------
  // registered control outputs
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      step_ph_q      <= 1'b0;
      o_lvol         <= 8'h00;
      o_rvol         <= 8'h00;
      o_rec_use_dsp  <= 1'b0;
      o_rec_block    <= 5'h01;
      o_rec_sel_bad  <= 1'b0;
      o_rec_jmp_cond <= 2'h0;
      o_rec_pc_clr   <= 1'b0;
      o_ply_jmp_cond <= 2'h0;
      o_ply_pc_clr   <= 1'b0;
      o_lpwr         <= 1'b0;
      o_rpwr         <= 1'b0;
      o_ldac         <= '0;
      o_rdac         <= '0;
      o_rmod         <= 1'b0;
      o_lmute        <= 1'b1;
      o_rmute        <= 1'b1;
    end else begin
      if (i_frame_stb) begin
        step_ph_q <= !step_ph_q;
        o_ldac    <= lsel;
        o_rdac    <= rsel;
      end
      o_lvol         <= lvol_d;
      o_rvol         <= rvol_d;
      o_rec_use_dsp  <= (rec_q[4:0] == dps_pkg::REC_SEL_DSP);
      o_rec_block    <= rec_q[4:0];
      o_rec_sel_bad  <= (rec_q[4:0] > dps_pkg::REC_SEL_LAST);
      o_rec_jmp_cond <= {dsp_q[dps_pkg::B_REC_AUX_A], dsp_q[dps_pkg::B_REC_AUX_B]};
      o_rec_pc_clr   <= i_frame_stb && !dsp_q[dps_pkg::B_REC_KEEP];
      o_ply_jmp_cond <= {dsp_q[dps_pkg::B_PLY_AUX_A], dsp_q[dps_pkg::B_PLY_AUX_B]};
      o_ply_pc_clr   <= i_frame_stb && !dsp_q[dps_pkg::B_PLY_KEEP];
      o_lpwr         <= pwr_q[dps_pkg::B_LPWR];
      o_rpwr         <= pwr_q[dps_pkg::B_RPWR];
      o_rmod         <= pwr_q[dps_pkg::B_RPWR] ? 1'b0 :
                        (mut_q[dps_pkg::B_RMOD_INV] ? !i_lmod : 1'b0);
      o_lmute        <= mut_q[dps_pkg::B_LMUTE] || lauto;
      o_rmute        <= mut_q[dps_pkg::B_RMUTE] || rauto;
    end
  end

endmodule

// *** verification/dps_regs_assertions.sv ***
// assertion checker for the dac path setup registers
`timescale 1ns/1ps
module dps_regs_chk (
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_sys_rst,
  // apb
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // frame and controls
  input wire logic        i_frame_stb,
  input wire logic        i_lmod,
  input wire logic        o_rec_use_dsp,
  input wire logic        o_rec_sel_bad,
  input wire logic [1:0]  o_rec_jmp_cond,
  input wire logic        o_rec_pc_clr,
  input wire logic [1:0]  o_ply_jmp_cond,
  input wire logic        o_ply_pc_clr,
  input wire logic        o_lpwr,
  input wire logic        o_rpwr,
  input wire logic        o_rmod,
  input wire logic        o_lmute,
  input wire logic        o_rmute
);
  logic [7:0] rec_q, dsp_q, pwr_q, mute_q;
  wire        tk = i_psel && i_penable && !o_pready && i_pwrite;
  // ---------------------------
  // shadow copies of the registers
  // ---------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rec_q  <= 8'h01;
      dsp_q  <= 8'h00;
      pwr_q  <= 8'h14;
      mute_q <= 8'h0C;
    end else if (tk) begin
      if (i_paddr == {2'h0, dps_pkg::ADDR_REC_SEL}) rec_q <= i_pwdata[7:0];
      if (i_paddr == {2'h0, dps_pkg::ADDR_DSP_CFG}) dsp_q <= i_pwdata[7:0];
      if (i_paddr == {2'h0, dps_pkg::ADDR_DAC_PWR}) pwr_q <= i_pwdata[7:0];
      if (i_paddr == {2'h0, dps_pkg::ADDR_DAC_MUTE}) mute_q <= i_pwdata[7:0];
    end
  end
  // ---------------------------
  // properties
  // ---------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  sequence s_take;
    i_psel && i_penable && !o_pready;
  endsequence
  AST_ANSWER: assert property (s_take |=> o_pready)
    else $error("no answer after access");
  AST_ERR_READY: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  AST_REC_SEL: assert property (o_pready |=>
    o_rec_use_dsp == (rec_q[4:0] == 5'h00) && o_rec_sel_bad == (rec_q[4:0] > 5'h12))
    else $error("record select decode wrong");
  AST_JMP: assert property (o_pready |=>
    o_rec_jmp_cond == dsp_q[6:5] && o_ply_jmp_cond == dsp_q[2:1])
    else $error("jump condition bits wrong");
  AST_PWR: assert property (o_pready |=> {o_lpwr, o_rpwr} == pwr_q[7:6])
    else $error("power bits wrong");
  AST_REC_CLR: assert property (o_rec_pc_clr == ($past(i_frame_stb) && !$past(dsp_q[4])))
    else $error("record counter clear wrong");
  AST_PLY_CLR: assert property (o_ply_pc_clr == ($past(i_frame_stb) && !$past(dsp_q[0])))
    else $error("playback counter clear wrong");
  AST_RMOD_ZERO: assert property (o_rpwr && $past(o_rpwr) |-> !o_rmod)
    else $error("right modulator not zero");
  AST_RMOD_INV: assert property (!o_rpwr && $past(!o_rpwr) && mute_q[7] &&
    $past(mute_q[7], 2) |-> o_rmod == !$past(i_lmod))
    else $error("right modulator not inverted left");
  AST_LMUTE: assert property (mute_q[3] && $past(mute_q[3]) |-> o_lmute)
    else $error("left not muted");
  AST_RMUTE: assert property (mute_q[2] && $past(mute_q[2]) |-> o_rmute)
    else $error("right not muted");
endmodule
bind dps_regs dps_regs_chk u_chk (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_frame_stb(i_frame_stb), .i_lmod(i_lmod),
  .o_rec_use_dsp(o_rec_use_dsp), .o_rec_sel_bad(o_rec_sel_bad),
  .o_rec_jmp_cond(o_rec_jmp_cond), .o_rec_pc_clr(o_rec_pc_clr),
  .o_ply_jmp_cond(o_ply_jmp_cond), .o_ply_pc_clr(o_ply_pc_clr), .o_lpwr(o_lpwr),
  .o_rpwr(o_rpwr), .o_rmod(o_rmod), .o_lmute(o_lmute), .o_rmute(o_rmute));

// *** verification/tb_dac_path_setup_regs.sv ***
// self-checking bench for the dac path setup registers
`timescale 1ns/1ps
module tb_dac_path_setup_regs;
  logic        clk, rst, psel, pen, pwr, fstb, lmod, rdy, err, e;
  logic        use_dsp, bad, lp, rp, rmod, lm, rm;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [31:0] seed = 32'hA031;
  logic [15:0] il, ir, ldac, rdac;
  logic [7:0]  lvs, rvs, lvol, rvol;
  logic [4:0]  blk;
  logic [9:0]  at [4] = '{dps_pkg::ADDR_REC_SEL, dps_pkg::ADDR_DSP_CFG,
                          dps_pkg::ADDR_DAC_PWR, dps_pkg::ADDR_DAC_MUTE};
  logic [7:0]  rt [4] = '{8'h01, 8'h00, 8'h14, 8'h0C};
  logic [7:0]  mt [4] = '{8'h1F, 8'h77, 8'hFF, 8'hFF};
  logic [4:0]  cs [5] = '{5'h00, 5'h01, 5'h12, 5'h13, 5'h1F};
  int          miscompares = 0;
  int          n_compared = 0;

  dps_regs #(.DW(16)) i_dut (
    .i_mclk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(rdy), .o_prdata(prdata),
    .o_pslverr(err), .i_frame_stb(fstb), .i_if_left(il), .i_if_right(ir),
    .i_lmod(lmod), .i_lvol_set(lvs), .i_rvol_set(rvs), .o_rec_use_dsp(use_dsp),
    .o_rec_block(blk), .o_rec_sel_bad(bad), .o_rec_jmp_cond(), .o_rec_pc_clr(),
    .o_ply_jmp_cond(), .o_ply_pc_clr(), .o_lpwr(lp), .o_rpwr(rp), .o_ldac(ldac),
    .o_rdac(rdac), .o_rmod(rmod), .o_lmute(lm), .o_rmute(rm), .o_lvol(lvol),
    .o_rvol(rvol));

  // ---------------------------
  // helpers
  // ---------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] route(input logic [1:0] s, input logic [15:0] a, b);
    logic signed [16:0] m;
    m = $signed({a[15], a}) + $signed({b[15], b});
    return (s == 2'h0) ? 16'h0000 : (s == 2'h1) ? a : (s == 2'h2) ? b : m[16:1];
  endfunction
  task automatic chk(input logic [31:0] g, x);
    n_compared++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] v);
    int n;
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= {2'h0, a};
    pwdata <= v;
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    rd = prdata;
    e = err;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
    if (n >= 20) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic frame(input int k);
    repeat (k) begin
      fstb <= 1;
      @(posedge clk);
      fstb <= 0;
      il <= (lm === 1'b1) ? il : il + 16'h0001;
      repeat (3) @(posedge clk);
    end
  endtask

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) lmod <= ^rnd();

  // ---------------------------
  // main sequence
  // ---------------------------
  initial begin
    {psel, pen, pwr, paddr, pwdata, fstb, lmod, il, ir, lvs, rvs} = '0;
    rst = 1;
    repeat (5) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 4; i++) begin
      apb(0, at[i], 0);
      chk(rd, {24'h0, rt[i]});
    end
    apb(0, 10'h0F0, 0);
    chk({31'h0, e}, 32'h1);
    chk(rd, 32'h0);
    for (int i = 0; i < 12; i++) begin
      d = rnd();
      apb(1, at[i%4], d);
      frame(1);
      apb(0, at[i%4], 0);
      chk(rd, {24'h0, d[7:0] & mt[i%4]});
    end
    foreach (cs[i]) begin
      apb(1, dps_pkg::ADDR_REC_SEL, {27'h0, cs[i]});
      @(posedge clk);
      chk({use_dsp, bad, blk}, {cs[i] == 5'h00, cs[i] > 5'h12, cs[i]});
    end
    apb(1, dps_pkg::ADDR_DAC_MUTE, 0);
    for (int s = 0; s < 4; s++) begin
      apb(1, dps_pkg::ADDR_DAC_PWR, {2'h3, s[1:0], s[1:0], 2'h2});
      ir <= rnd();
      il <= rnd();
      frame(1);
      chk(ldac, route(s[1:0], il - 16'h1, ir));
      chk(rdac, route(s[1:0], ir, il - 16'h1));
    end
    lvs <= rnd();
    rvs <= rnd();
    for (int g = 0; g < 3; g++) begin
      apb(1, dps_pkg::ADDR_DAC_MUTE, g);
      frame(2);
      chk({lvol, rvol}, {(g == 1) ? rvs : lvs, (g == 2) ? lvs : rvs});
    end
    lvs <= 8'h00;
    frame(2);
    apb(1, dps_pkg::ADDR_DAC_PWR, 8'hD4);
    lvs <= 8'h10;
    frame(4);
    chk(lvol, 8'h04);
    apb(1, dps_pkg::ADDR_DAC_PWR, 8'hD5);
    frame(4);
    chk(lvol, 8'h06);
    apb(1, dps_pkg::ADDR_DAC_MUTE, 8'h10);
    ir <= 16'h1234;
    frame(90);
    chk(rm, 0);
    frame(20);
    chk(rm, 1);
    apb(1, dps_pkg::ADDR_DAC_PWR, 8'h14);
    apb(1, dps_pkg::ADDR_DAC_MUTE, 8'h80);
    frame(3);
    chk(lp, 0);
    tally_and_finish();
  end
endmodule
